// [rtl/dcic_top.sv]
// Design decisions made here: the placing of the registers and the APB register port.
`include "dcic_defs.svh"
module dcic_top
    import dcic_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        capture_input_zero,
    input  wire logic        capture_input_one,
    input  wire logic [15:0] timer_zero_count,
    input  wire logic [15:0] timer_one_count,
    input  wire logic        stop_mode,
    output logic [1:0]       capture_irq
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] ch_fclk(input logic [15:0] m, input int c);
        ch_fclk = m[c*`DCIC_CH_STRIDE + `DCIC_MODE_FCLK +: 2];
    endfunction

    function automatic logic [15:0] tap(input logic [15:0] m, input int c,
                                        input logic [15:0] t0, input logic [15:0] t1);
        tap = m[c*`DCIC_CH_STRIDE + `DCIC_MODE_SRC] ? t1 : t0;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] mode_r, mode_nxt;
    logic [1:0]  ptr_r, ptr_nxt;
    logic [1:0]  last_r, last_nxt;
    logic [1:0]  req_r, req_nxt;
    logic [1:0]  pend_r, pend_nxt;
    logic [1:0]  lvl_r, lvl_nxt;
    logic [1:0]  shf_r [2];
    logic [1:0]  shf_nxt [2];
    logic [5:0]  div_r, div_nxt;
    logic [1:0]  irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic [1:0]  tick;
    logic [1:0]  rise, fall;
    logic [3:0]  cap;
    logic [3:0]  swt;
    logic        wr_acc, rd_acc;
    logic        pin [2];
    logic [1:0]  hist_r, hist_nxt;

    function automatic logic div_hist(input int c);
        div_hist = (hist_r[c] == pin[c]);
    endfunction

    dcic_lat_if lat ();
    dcic_latch_mem u_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .lat     (lat)
    );

    assign pin[0] = capture_input_zero;
    assign pin[1] = capture_input_one;
    assign wr_acc = psel && penable && pwrite && pready_r;
    assign rd_acc = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // Filter, edges, capture
    // ------------------------------------------------------------
    always_comb
    begin
        div_nxt = div_r + 6'h01;
        for (int c = 0; c < 2; c++)
        begin
            unique case (ch_fclk(mode_r, c))
                2'h0: tick[c] = 1'b1;
                2'h1: tick[c] = (div_r[2:0] == 3'h0);
                2'h2: tick[c] = (div_r[4:0] == 5'h00);
                2'h3: tick[c] = (div_r == 6'h00);
            endcase
        end
    end

    always_comb
    begin
        swt = (wr_acc && paddr == `DCIC_OFF_TRIG) ? pwdata[3:0] : 4'h0;
        for (int c = 0; c < 2; c++)
        begin
            shf_nxt[c] = shf_r[c];
            lvl_nxt[c] = lvl_r[c];
            rise[c] = 1'b0;
            fall[c] = 1'b0;
            if (tick[c])
            begin
                shf_nxt[c] = {shf_r[c][0], pin[c]};
                if (shf_r[c] == {2{pin[c]}} && div_hist(c) && lvl_r[c] != pin[c])
                begin
                    lvl_nxt[c] = pin[c];
                    rise[c] = pin[c];
                    fall[c] = !pin[c];
                end
            end
        end
        cap = {fall[1] | swt[3], rise[1] | swt[2], fall[0] | swt[1], rise[0] | swt[0]};
    end

    // Fourth (oldest) sample of the run is held in history flop hist_r, loaded from shf_r on each tick
    always_comb
    begin
        for (int c = 0; c < 2; c++)
            hist_nxt[c] = tick[c] ? shf_r[c][1] : hist_r[c];
    end

    // ------------------------------------------------------------
    // Latch write: one port, lower latch index wins a collision
    // ------------------------------------------------------------
    always_comb
    begin
        lat.we = |cap;
        lat.waddr = 2'h0;
        for (int i = 3; i >= 0; i--)
            if (cap[i])
                lat.waddr = 2'(i);
        lat.wdata = tap(mode_r, int'(lat.waddr[1]), timer_zero_count, timer_one_count);
        lat.raddr = ptr_r;
    end

    // ------------------------------------------------------------
    // Status and interrupt requests
    // ------------------------------------------------------------
    always_comb
    begin
        last_nxt = last_r;
        req_nxt = req_r;
        pend_nxt = pend_r;
        for (int c = 0; c < 2; c++)
        begin
            logic ev;
            dcic_edge_t es;
            ev = 1'b0;
            es = dcic_edge_t'(mode_r[c*`DCIC_CH_STRIDE + `DCIC_MODE_EDGE +: 2]);
            if (cap[2*c] || cap[2*c+1])
                last_nxt[c] = cap[2*c+1];
            unique case (es)
                DCIC_IRQ_RISE: ev = rise[c];
                DCIC_IRQ_FALL: ev = fall[c];
                DCIC_IRQ_BOTH: ev = rise[c] | fall[c];
                DCIC_IRQ_OFF:  ev = 1'b0;
            endcase
            if (wr_acc && paddr == `DCIC_OFF_STAT && pwdata[`DCIC_STAT_REQ + c])
                req_nxt[c] = 1'b0;
            if (ev && stop_mode)
                pend_nxt[c] = 1'b1;
            if ((ev && !stop_mode) || (pend_r[c] && !stop_mode))
            begin
                req_nxt[c] = 1'b1;
                pend_nxt[c] = 1'b0;
            end
        end
        irq_nxt = req_nxt;
    end

    // ------------------------------------------------------------
    // APB
    // ------------------------------------------------------------
    always_comb
    begin
        mode_nxt = mode_r;
        ptr_nxt = ptr_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        if (psel && !penable)
        begin
            // Read data is taken in setup, so the access needs no wait state
            pready_nxt = 1'b1;
        end
        if (wr_acc && paddr == `DCIC_OFF_MODE)
            // setting changes leave the filter samples, level and requests untouched
            mode_nxt = pwdata[15:0];
        if (wr_acc && paddr == `DCIC_OFF_PTR)
            ptr_nxt = pwdata[1:0];
        if (rd_acc)
        begin
            unique case (paddr)
                `DCIC_OFF_MODE: prdata_nxt = {16'h0000, mode_r};
                `DCIC_OFF_TRIG: prdata_nxt = 32'h0000_0000;
                `DCIC_OFF_PTR:  prdata_nxt = {30'h0, ptr_r};
                `DCIC_OFF_LOW:  prdata_nxt = {24'h0, lat.rdata[7:0]};
                `DCIC_OFF_HIGH: prdata_nxt = {24'h0, lat.rdata[15:8]};
                `DCIC_OFF_STAT: prdata_nxt = {26'h0, lvl_r, req_r, last_r};
                default:        prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= `DCIC_MODE_RST;
            ptr_r <= 2'h0;
            last_r <= 2'h0;
            req_r <= 2'h0;
            pend_r <= 2'h0;
            lvl_r <= 2'h0;
            shf_r[0] <= 2'h0;
            shf_r[1] <= 2'h0;
            hist_r <= 2'h0;
            div_r <= 6'h00;
            irq_r <= 2'h0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            ptr_r <= ptr_nxt;
            last_r <= last_nxt;
            req_r <= req_nxt;
            pend_r <= pend_nxt;
            lvl_r <= lvl_nxt;
            shf_r[0] <= shf_nxt[0];
            shf_r[1] <= shf_nxt[1];
            hist_r <= hist_nxt;
            div_r <= div_nxt;
            irq_r <= irq_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = 1'b0;
    assign capture_irq = irq_r;
endmodule

// [rtl/dcic_defs.svh]
`ifndef DCIC_DEFS_SVH
`define DCIC_DEFS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define DCIC_OFF_MODE  12'h000
`define DCIC_OFF_TRIG  12'h004
`define DCIC_OFF_PTR   12'h008
`define DCIC_OFF_LOW   12'h00C
`define DCIC_OFF_HIGH  12'h010
`define DCIC_OFF_STAT  12'h014
// ------------------------------------------------------------
// Mode register fields, channel c at base 8*c
// ------------------------------------------------------------
`define DCIC_MODE_SRC   0
`define DCIC_MODE_EDGE  1
`define DCIC_MODE_FCLK  3
`define DCIC_MODE_PORT  5
`define DCIC_CH_STRIDE  8
`define DCIC_MODE_RST   16'h0000
// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define DCIC_STAT_LAST  0
`define DCIC_STAT_REQ   2
`define DCIC_STAT_LVL   4
// ------------------------------------------------------------
// Filter
// ------------------------------------------------------------
`define DCIC_FILT_LEN   4
`define DCIC_DIV1       1
`define DCIC_DIV2       8
`define DCIC_DIV3       32
`endif

// [rtl/dcic_pkg.sv]
package dcic_pkg;
    typedef enum logic [1:0] {DCIC_IRQ_RISE, DCIC_IRQ_FALL, DCIC_IRQ_BOTH, DCIC_IRQ_OFF}
        dcic_edge_t;
    typedef logic [15:0] dcic_cnt_t;
endpackage

// [rtl/dcic_if.sv]
interface dcic_lat_if;
    logic       we;
    logic [1:0] waddr;
    logic [15:0] wdata;
    logic [1:0] raddr;
    logic [15:0] rdata;
    modport ctl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// [rtl/dcic_latch_mem.sv]
module dcic_latch_mem
(
    input  wire logic pclk,
    input  wire logic presetn,
    dcic_lat_if.mem   lat
);
    logic [15:0] mem_r [4];
    logic [15:0] rd_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_r <= 16'h0000;
            for (int i = 0; i < 4; i++)
                mem_r[i] <= 16'h0000;
        end
        else
        begin
            if (lat.we)
                mem_r[lat.waddr] <= lat.wdata;
            rd_r <= mem_r[lat.raddr];
        end
    end
    assign lat.rdata = rd_r;
endmodule

// [dv/dcic_far_model.sv]
module dcic_far_model
(
    input  wire logic        pclk,
    input  wire logic [15:0] ld0,
    input  wire logic [15:0] ld1,
    input  wire logic [1:0]  lvl,
    output logic [15:0]      t0,
    output logic [15:0]      t1,
    output logic [1:0]       pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // plain timer sources
    // Counts held by the bench so a capture value is known exactly
    assign t0 = ld0;
    assign t1 = ld1;
    assign pin = lvl;
endmodule

// [dv/dcic_checker.sv]
`include "dcic_defs.svh"
module dcic_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        capture_input_zero,
    input wire logic        capture_input_one,
    input wire logic [15:0] timer_zero_count,
    input wire logic [15:0] timer_one_count,
    input wire logic        stop_mode,
    input wire logic [1:0]  capture_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bus phases, read data and interrupt requests
    // ----------------------------------------
    sequence rd_s;
        psel && penable && pready && !pwrite;
    endsequence
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    ready_cause_a: assert property (pready |-> psel && penable)
        else $error("pready stray");
    no_slverr_a: assert property (!pslverr)
        else $error("pslverr high");
    trig_zero_a: assert property (rd_s ##0 paddr == `DCIC_OFF_TRIG |-> prdata[3:0] == 4'h0)
        else $error("trigger bits read back");
    unmapped_zero_a: assert property (rd_s ##0 paddr > `DCIC_OFF_STAT |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("prdata moved without read");
    irq_clear_a: assert property ($fell(capture_irq[0]) |->
        $past(psel && penable && pwrite && paddr == `DCIC_OFF_STAT && pwdata[`DCIC_STAT_REQ]))
        else $error("request dropped uncleared");
    stop_hold_a: assert property ($rose(capture_irq[0]) |-> !$past(stop_mode))
        else $error("request during stop");
endmodule
bind dcic_top dcic_checker dcic_checker_i (.*);

// [dv/test_dual_channel_input_capture.sv]
`include "dcic_defs.svh"
module test_dual_channel_input_capture;
    import dcic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] F = 32'hFFFFFFFF;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [1:0]  pin;
    logic [1:0]  lvl = 2'h0;
    logic [15:0] t0;
    logic [15:0] t1;
    logic [15:0] ld0 = 16'h0000;
    logic [15:0] ld1 = 16'h0000;
    logic        stop = 1'b0;
    logic [1:0]  irq;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          error_cnt = 0;
    int          n_checks = 0;
    integer      seed = 69;
    always #20 pclk = ~pclk;
    dcic_top dcic_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .capture_input_zero(pin[0]), .capture_input_one(pin[1]),
        .timer_zero_count(t0), .timer_one_count(t1), .stop_mode(stop), .capture_irq(irq));
    dcic_far_model dcic_far_model_i (.pclk, .ld0, .ld1, .lvl, .t0, .t1, .pin);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    // pointer, then halves; counts held still so one read suffices
    task automatic latch(logic [1:0] i, logic [15:0] e);
        apb(1'b1, `DCIC_OFF_PTR, {30'h0, i});
        rd(`DCIC_OFF_LOW, {24'h0, e[7:0]}, F);
        rd(`DCIC_OFF_HIGH, {24'h0, e[15:8]}, F);
    endtask
    task automatic irq_is(int c, logic e);
        cyc(12);
        chk("capture_irq", {31'h0, e}, {31'h0, irq[c]});
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
        begin : mon
            logic [31:0] e;
            logic [31:0] m;
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk("prdata", e & m, prdata & m);
        end
    initial
    begin
        cyc(20000);
        error_cnt++;
        end_of_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin : main
        logic [15:0] v;
        int          c;
        int          m;
        cyc(16);
        presetn <= 1'b1;
        rd(`DCIC_OFF_MODE, 32'h0, F);
        rd(`DCIC_OFF_STAT, 32'h0, F);
        apb(1'b1, 12'h018, F);
        rd(12'h018, 32'h0, F);
        for (int i = 0; i < 8; i++)
        begin
            ld0 <= 16'($random(seed));
            ld1 <= 16'($random(seed));
            apb(1'b1, `DCIC_OFF_MODE, i[2] ? 32'h2121 : 32'h2020);
            apb(1'b1, `DCIC_OFF_TRIG, 32'h1 << i[1:0]);
            rd(`DCIC_OFF_TRIG, 32'h0, 32'hF);
            latch(i[1:0], i[2] ? ld1 : ld0);
            rd(`DCIC_OFF_STAT, i[0] << i[1], 32'h1 << i[1]);
        end
        for (int k = 0; k < 8; k++)
        begin
            c = k % 2;
            m = k / 2;
            v = 16'($random(seed));
            ld0 <= v;
            ld1 <= v;
            apb(1'b1, `DCIC_OFF_MODE, 32'h2020 | (m << 1) | (m << 9));
            apb(1'b1, `DCIC_OFF_STAT, 32'hC);
            lvl[c] <= 1'b1;
            irq_is(c, m == 0 || m == 2);
            ld0 <= ~v;
            ld1 <= ~v;
            cyc(2);
            lvl[c] <= 1'b0;
            irq_is(c, m != 3);
            ld0 <= v ^ 16'hA5A5;
            ld1 <= v ^ 16'hA5A5;
            lvl[c] <= 1'b1;
            cyc(3);
            lvl[c] <= 1'b0;
            cyc(12);
            latch(2'(2 * c), v);
            latch(2'(2 * c + 1), ~v);
            rd(`DCIC_OFF_STAT, 32'h1 << c, 32'h1 << c);
        end
        apb(1'b1, `DCIC_OFF_MODE, 32'h202C);
        apb(1'b1, `DCIC_OFF_STAT, 32'hC);
        lvl[0] <= 1'b1;
        cyc(12);
        lvl[0] <= 1'b0;
        irq_is(0, 1'b0);
        lvl[0] <= 1'b1;
        cyc(68);
        irq_is(0, 1'b1);
        apb(1'b1, `DCIC_OFF_MODE, 32'h2020);
        apb(1'b1, `DCIC_OFF_STAT, 32'hC);
        stop <= 1'b1;
        lvl[0] <= 1'b0;
        cyc(12);
        lvl[0] <= 1'b1;
        irq_is(0, 1'b0);
        stop <= 1'b0;
        irq_is(0, 1'b1);
        end_of_test();
    end
endmodule
